// File: gio_pkg.sv
// ==========================================================================
// Notes on behaviour
// RULE1: Direction one drives the latch onto the pin; zero leaves pin undriven.
// RULE2: Reset clears all eight port E direction bits, so pins not owned by serial or timer blocks are inputs.
// RULE3: Reset clears port F, G and H direction bits, so pins other than timer-owned port F pins are inputs.
// RULE4: Port E data read returns latch for outputs, pin level for inputs.
// RULE5: Port F data read picks latch or live pin level bit by bit.
// RULE6: Port G data read returns latch where direction is one, else pin.
// RULE7: Port H data read returns latch where direction is one, else pin.
// RULE8: Latches always take writes; an input pin read is never affected.
// RULE9: Reset leaves the seven port F data latches unchanged.
// RULE10: Reset leaves the port G and port H data latches unchanged.
// RULE11: Port F pins 3..0 carry timer A channels 5..2 when selected.
// RULE12: Port F pins 5..4 carry timer B channels 1..0 when selected.
// RULE13: Timer-owned port F pins ignore direction for drive, not for reads.
// RULE14: Port G pins feed keyboard inputs 2..0 when their enables are set.
// RULE15: Port H pins feed keyboard inputs 4..3 when their enables are set.
// RULE16: Software should load a latch before turning its pin to output.
// RULE17: Port F has seven pins, G three, H two, each latch plus direction.
// RULE18: Every direction bit reads back the last written or reset value.
// RULE19: Port E pins used by serial or timer blocks ignore direction drive.
// RULE20: Unused upper bits of narrow registers read zero and ignore writes.
package gio_pkg;

  // ========================================================================
  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ========================================================================
  // Register offsets
  localparam logic [15:0] OFS_E_DATA = 16'h0008;
  localparam logic [15:0] OFS_F_DATA = 16'h0009;
  localparam logic [15:0] OFS_G_DATA = 16'h000A;
  localparam logic [15:0] OFS_H_DATA = 16'h000B;
  localparam logic [15:0] OFS_E_DIR  = 16'h000C;
  localparam logic [15:0] OFS_F_DIR  = 16'h000D;
  localparam logic [15:0] OFS_G_DIR  = 16'h000E;
  localparam logic [15:0] OFS_H_DIR  = 16'h000F;

  // ========================================================================
  // Port widths
  localparam int E_W = 8;
  localparam int F_W = 7; // RULE17
  localparam int G_W = 3; // RULE17
  localparam int H_W = 2; // RULE17

  // ========================================================================
  // Reset values of direction registers and of the read data register
  localparam logic [7:0] E_DIR_RST = 8'h00;
  localparam logic [6:0] F_DIR_RST = 7'h00;
  localparam logic [2:0] G_DIR_RST = 3'h0;
  localparam logic [1:0] H_DIR_RST = 2'h0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ========================================================================
  // Alternate function layout
  localparam int ELS_W    = 2;
  localparam int TA_CH_N  = 4;
  localparam int TB_CH_N  = 2;
  localparam int TA_F_LSB = 0;
  localparam int TB_F_LSB = 4;
  localparam int KB_N     = 5;
  localparam int KB_G_LSB = 0;
  localparam int KB_H_LSB = 3;

endpackage : gio_pkg

// File: gio_bank.sv
`timescale 1ns/1ps
// Latch, direction and pin logic for one port of W pins
module gio_bank #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Register writes
  input  wire logic         wr_data,
  input  wire logic         wr_dir,
  input  wire logic [7:0]   wdata,
  // Pins
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  // Alternate function ownership
  input  wire logic [W-1:0] alt_sel,
  input  wire logic [W-1:0] alt_out,
  input  wire logic [W-1:0] alt_oe,
  // State seen by the register file
  output logic      [W-1:0] latch,
  output logic      [W-1:0] dir,
  output logic      [W-1:0] rd_val
);

  typedef struct packed {
    logic [W-1:0] latch;
    logic [W-1:0] dir;
  } gio_bank_s;

  gio_bank_s st;
  gio_bank_s next_st;

  // ========================================================================
  // Next state: latches take writes regardless of direction
  always_comb begin
    next_st = st;
    if (wr_data) begin
      next_st.latch = wdata[W-1:0]; // RULE8 RULE20
    end
    if (wr_dir) begin
      next_st.dir = wdata[W-1:0]; // RULE18 RULE20
    end
  end

  // ========================================================================
  // Registers; reset touches direction only
  always_ff @(posedge clk) begin
    st <= next_st; // RULE9 RULE10
    if (rst) begin
      st.dir <= '0; // RULE2 RULE3
    end
  end

  assign latch = st.latch;
  assign dir   = st.dir;

  // ========================================================================
  // Per pin drive and read source
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      // Owner picks the buffer; direction always picks the read source
      assign pin_oe[i]  = alt_sel[i] ? alt_oe[i] : st.dir[i]; // RULE1 RULE13 RULE19
      assign pin_out[i] = alt_sel[i] ? alt_out[i] : st.latch[i]; // RULE1
      assign rd_val[i]  = st.dir[i] ? st.latch[i] : pin_in[i]; // RULE8 RULE13
    end
  endgenerate

endmodule : gio_bank

// File: gio_alt_sel.sv
`timescale 1ns/1ps
// Timer channel ownership of port F and keyboard feeds from ports G and H
module gio_alt_sel (
  // Timer edge/level select fields, two bits per channel
  input  wire logic [7:0] timer_a_edge_level_select,
  input  wire logic [3:0] timer_b_edge_level_select,
  // Keyboard enables and pin levels
  input  wire logic [4:0] keyboard_irq_enable,
  input  wire logic [2:0] pg_in,
  input  wire logic [1:0] ph_in,
  // Results
  output logic      [6:0] pf_sel,
  output logic      [4:0] keyboard_input
);

  logic [4:0] kb_pins;

  // ========================================================================
  // A channel owns its pin when its select field is nonzero
  genvar c;
  generate
    for (c = 0; c < gio_pkg::TA_CH_N; c++) begin : g_ta
      assign pf_sel[gio_pkg::TA_F_LSB+c] =
        |timer_a_edge_level_select[c*gio_pkg::ELS_W +: gio_pkg::ELS_W]; // RULE11
    end
    for (c = 0; c < gio_pkg::TB_CH_N; c++) begin : g_tb
      assign pf_sel[gio_pkg::TB_F_LSB+c] =
        |timer_b_edge_level_select[c*gio_pkg::ELS_W +: gio_pkg::ELS_W]; // RULE12
    end
  endgenerate

  // Pin 6 has no alternate owner
  assign pf_sel[6] = 1'b0;

  // ========================================================================
  // Keyboard inputs gated by their enables
  assign kb_pins        = {ph_in, pg_in};
  assign keyboard_input = kb_pins & keyboard_irq_enable; // RULE14 RULE15

endmodule : gio_alt_sel

// File: gio_ports_e_to_h.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
// General purpose ports E, F, G and H behind a plain register port
module gio_ports_e_to_h (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // Port E pins
  input  wire logic [7:0]  pe_in,
  output logic      [7:0]  pe_out,
  output logic      [7:0]  pe_oe,
  // Port E owners: serial and timer A blocks
  input  wire logic [7:0]  pe_alt_sel,
  input  wire logic [7:0]  pe_alt_out,
  input  wire logic [7:0]  pe_alt_oe,
  // Port F pins
  input  wire logic [6:0]  pf_in,
  output logic      [6:0]  pf_out,
  output logic      [6:0]  pf_oe,
  // Timer A channels 5..2 on port F 3..0
  input  wire logic [7:0]  timer_a_edge_level_select,
  input  wire logic [3:0]  timer_a_channel_pins_out,
  input  wire logic [3:0]  timer_a_channel_pins_oe,
  output logic      [3:0]  timer_a_channel_pins_in,
  // Timer B channels 1..0 on port F 5..4
  input  wire logic [3:0]  timer_b_edge_level_select,
  input  wire logic [1:0]  timer_b_channel_pins_out,
  input  wire logic [1:0]  timer_b_channel_pins_oe,
  output logic      [1:0]  timer_b_channel_pins_in,
  // Port G pins
  input  wire logic [2:0]  pg_in,
  output logic      [2:0]  pg_out,
  output logic      [2:0]  pg_oe,
  // Port H pins
  input  wire logic [1:0]  ph_in,
  output logic      [1:0]  ph_out,
  output logic      [1:0]  ph_oe,
  // Keyboard block
  input  wire logic [4:0]  keyboard_irq_enable,
  output logic      [4:0]  keyboard_input
);

  typedef struct packed {
    logic [7:0] rdata;
    logic [2:0] written; // Latches H, G, F written since power up
  } gio_top_s;

  gio_top_s st;
  gio_top_s next_st;

  logic [7:0] e_latch;
  logic [7:0] e_dir;
  logic [7:0] e_rd;
  logic [6:0] f_latch;
  logic [6:0] f_dir;
  logic [6:0] f_rd;
  logic [2:0] g_latch;
  logic [2:0] g_dir;
  logic [2:0] g_rd;
  logic [1:0] h_latch;
  logic [1:0] h_dir;
  logic [1:0] h_rd;
  logic [6:0] pf_sel;
  logic [6:0] pf_alt_out;
  logic [6:0] pf_alt_oe;

  // ========================================================================
  // Write decode
  logic we_e_data;
  logic we_f_data;
  logic we_g_data;
  logic we_h_data;
  logic we_e_dir;
  logic we_f_dir;
  logic we_g_dir;
  logic we_h_dir;

  assign we_e_data = wr && (addr == gio_pkg::OFS_E_DATA);
  assign we_f_data = wr && (addr == gio_pkg::OFS_F_DATA);
  assign we_g_data = wr && (addr == gio_pkg::OFS_G_DATA);
  assign we_h_data = wr && (addr == gio_pkg::OFS_H_DATA);
  assign we_e_dir  = wr && (addr == gio_pkg::OFS_E_DIR);
  assign we_f_dir  = wr && (addr == gio_pkg::OFS_F_DIR);
  assign we_g_dir  = wr && (addr == gio_pkg::OFS_G_DIR);
  assign we_h_dir  = wr && (addr == gio_pkg::OFS_H_DIR);

  // ========================================================================
  // Alternate function selection
  gio_alt_sel u_alt (
    .timer_a_edge_level_select (timer_a_edge_level_select),
    .timer_b_edge_level_select (timer_b_edge_level_select),
    .keyboard_irq_enable       (keyboard_irq_enable),
    .pg_in                     (pg_in),
    .ph_in                     (ph_in),
    .pf_sel                    (pf_sel),
    .keyboard_input            (keyboard_input)
  );

  // Timer drive merged onto port F, pin 6 has none
  assign pf_alt_out = {1'b0, timer_b_channel_pins_out, timer_a_channel_pins_out}; // RULE11 RULE12
  assign pf_alt_oe  = {1'b0, timer_b_channel_pins_oe, timer_a_channel_pins_oe}; // RULE11 RULE12
  assign timer_a_channel_pins_in = pf_in[3:0]; // RULE11
  assign timer_b_channel_pins_in = pf_in[5:4]; // RULE12

  // ========================================================================
  // Port banks
  gio_bank #(.W(gio_pkg::E_W)) u_e (
    .clk     (clk),
    .rst     (rst),
    .wr_data (we_e_data),
    .wr_dir  (we_e_dir),
    .wdata   (wdata),
    .pin_in  (pe_in),
    .pin_out (pe_out),
    .pin_oe  (pe_oe),
    .alt_sel (pe_alt_sel),
    .alt_out (pe_alt_out),
    .alt_oe  (pe_alt_oe),
    .latch   (e_latch),
    .dir     (e_dir),
    .rd_val  (e_rd)
  );

  gio_bank #(.W(gio_pkg::F_W)) u_f (
    .clk     (clk),
    .rst     (rst),
    .wr_data (we_f_data),
    .wr_dir  (we_f_dir),
    .wdata   (wdata),
    .pin_in  (pf_in),
    .pin_out (pf_out),
    .pin_oe  (pf_oe),
    .alt_sel (pf_sel),
    .alt_out (pf_alt_out),
    .alt_oe  (pf_alt_oe),
    .latch   (f_latch),
    .dir     (f_dir),
    .rd_val  (f_rd)
  );

  gio_bank #(.W(gio_pkg::G_W)) u_g (
    .clk     (clk),
    .rst     (rst),
    .wr_data (we_g_data),
    .wr_dir  (we_g_dir),
    .wdata   (wdata),
    .pin_in  (pg_in),
    .pin_out (pg_out),
    .pin_oe  (pg_oe),
    .alt_sel (3'h0),
    .alt_out (3'h0),
    .alt_oe  (3'h0),
    .latch   (g_latch),
    .dir     (g_dir),
    .rd_val  (g_rd)
  );

  gio_bank #(.W(gio_pkg::H_W)) u_h (
    .clk     (clk),
    .rst     (rst),
    .wr_data (we_h_data),
    .wr_dir  (we_h_dir),
    .wdata   (wdata),
    .pin_in  (ph_in),
    .pin_out (ph_out),
    .pin_oe  (ph_oe),
    .alt_sel (2'h0),
    .alt_out (2'h0),
    .alt_oe  (2'h0),
    .latch   (h_latch),
    .dir     (h_dir),
    .rd_val  (h_rd)
  );

  // ========================================================================
  // Read decode; data stands one cycle after the strobe only
  always_comb begin
    next_st       = st;
    next_st.rdata = 8'h00;
    // Written marks let the checks skip latches that still hold nothing
    next_st.written = st.written | {we_h_data, we_g_data, we_f_data};
    if (!rd) begin
      next_st.rdata = 8'h00;
    end else if (addr == gio_pkg::OFS_E_DATA) begin
      next_st.rdata = e_rd; // RULE4
    end else if (addr == gio_pkg::OFS_F_DATA) begin
      next_st.rdata = {1'b0, f_rd}; // RULE5 RULE20
    end else if (addr == gio_pkg::OFS_G_DATA) begin
      next_st.rdata = {5'h00, g_rd}; // RULE6 RULE20
    end else if (addr == gio_pkg::OFS_H_DATA) begin
      next_st.rdata = {6'h00, h_rd}; // RULE7 RULE20
    end else if (addr == gio_pkg::OFS_E_DIR) begin
      next_st.rdata = e_dir; // RULE18
    end else if (addr == gio_pkg::OFS_F_DIR) begin
      next_st.rdata = {1'b0, f_dir}; // RULE18 RULE20
    end else if (addr == gio_pkg::OFS_G_DIR) begin
      next_st.rdata = {5'h00, g_dir}; // RULE18 RULE20
    end else if (addr == gio_pkg::OFS_H_DIR) begin
      next_st.rdata = {6'h00, h_dir}; // RULE18 RULE20
    end else begin
      next_st.rdata = 8'h00; // Unmapped reads return zero
    end
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (rst) begin
      st.rdata <= gio_pkg::RDATA_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  dir_e_reset_a: assert property ( // RULE2
    @(posedge clk) disable iff (1'b0)
      rst |=> (e_dir == gio_pkg::E_DIR_RST) && (pe_oe == (pe_alt_sel & pe_alt_oe))
  ) else $error("port E direction not cleared by reset");

  dir_fgh_reset_a: assert property ( // RULE3
    @(posedge clk) disable iff (1'b0) rst |=> (f_dir == 7'h00) && (g_dir == 3'h0) && (h_dir == 2'h0)
  ) else $error("port F G H direction not cleared by reset");

  latch_f_hold_a: assert property ( // RULE9
    @(posedge clk) disable iff (1'b0)
      (rst && st.written[0] && !we_f_data) |=> f_latch == $past(f_latch)
  ) else $error("port F latch changed by reset");

  latch_gh_hold_a: assert property ( // RULE10
    @(posedge clk) disable iff (1'b0)
      (rst && (st.written[2:1] == 2'b11) && !we_g_data && !we_h_data)
      |=> (g_latch == $past(g_latch)) && (h_latch == $past(h_latch))
  ) else $error("port G or H latch changed by reset");

  read_e_mux_a: assert property ( // RULE4
    (rd && addr == gio_pkg::OFS_E_DATA)
      |=> rdata == (($past(e_latch) & $past(e_dir)) | ($past(pe_in) & ~$past(e_dir)))
  ) else $error("port E read source wrong");

  read_f_mux_a: assert property ( // RULE5
    (rd && addr == gio_pkg::OFS_F_DATA)
      |=> rdata == {1'b0, ($past(f_latch) & $past(f_dir)) | ($past(pf_in) & ~$past(f_dir))}
  ) else $error("port F read source wrong");

  read_g_mux_a: assert property ( // RULE6
    (rd && addr == gio_pkg::OFS_G_DATA)
      |=> rdata == {5'h00, ($past(g_latch) & $past(g_dir)) | ($past(pg_in) & ~$past(g_dir))}
  ) else $error("port G read source wrong");

  read_h_mux_a: assert property ( // RULE7
    (rd && addr == gio_pkg::OFS_H_DATA)
      |=> rdata == {6'h00, ($past(h_latch) & $past(h_dir)) | ($past(ph_in) & ~$past(h_dir))}
  ) else $error("port H read source wrong");

  write_input_a: assert property ( // RULE8
    (we_g_data && g_dir == 3'h0) ##1 (rd && addr == gio_pkg::OFS_G_DATA && g_dir == 3'h0)
      |=> (rdata == {5'h00, $past(pg_in)}) && (g_latch == $past(wdata[2:0], 2))
  ) else $error("write to input pin disturbed read or missed latch");

  pin_drive_a: assert property ( // RULE1
    (st.written[2:1] == 2'b11)
      |-> (pg_oe == g_dir) && (pg_out == g_latch) && (ph_oe == h_dir) && (ph_out == h_latch)
  ) else $error("pin buffer does not follow direction and latch");

  timer_own_a: assert property ( // RULE13
    (pf_sel[0] && we_f_dir) |=> (pf_oe[0] == timer_a_channel_pins_oe[0])
      && (pf_out[0] == timer_a_channel_pins_out[0])
  ) else $error("timer owned pin followed direction bit");

  timer_b_sel_a: assert property ( // RULE12
    (timer_b_edge_level_select[1:0] != 2'h0) |-> pf_oe[4] == timer_b_channel_pins_oe[0]
  ) else $error("timer B channel 0 not routed to port F pin 4");

  serial_own_a: assert property ( // RULE19
    pe_alt_sel[0] |-> (pe_oe[0] == pe_alt_oe[0]) && (pe_out[0] == pe_alt_out[0])
  ) else $error("owned port E pin followed direction bit");

  keyboard_feed_a: assert property ( // RULE14
    keyboard_irq_enable[0] |-> keyboard_input[0] == pg_in[0]
  ) else $error("keyboard input 0 not fed from port G");

  dir_readback_a: assert property ( // RULE18
    (we_h_dir ##1 (rd && addr == gio_pkg::OFS_H_DIR && !we_h_dir))
      |=> rdata == {6'h00, $past(wdata[1:0], 2)}
  ) else $error("direction readback mismatch");

  upper_zero_a: assert property ( // RULE20
    (rd && addr == gio_pkg::OFS_F_DIR) |=> rdata[7] == 1'b0
  ) else $error("unused upper bit read as one");

  rdata_idle_a: assert property (
    !rd |=> rdata == 8'h00
  ) else $error("read data stands outside its cycle");

  keyboard_h_a: assert property ( // RULE15
    keyboard_irq_enable[3] |-> keyboard_input[3] == ph_in[0]
  ) else $error("keyboard input 3 not fed from port H");

  kb_gate_a: assert property ( // RULE14
    !keyboard_irq_enable[1] |-> !keyboard_input[1]
  ) else $error("disabled keyboard input 1 passed a level");

  timer_a_sel_a: assert property ( // RULE11
    (timer_a_edge_level_select[1:0] != 2'h0)
      |-> (pf_oe[0] == timer_a_channel_pins_oe[0]) && (pf_out[0] == timer_a_channel_pins_out[0])
  ) else $error("timer A channel 2 not routed to port F pin 0");

  timer_b1_sel_a: assert property ( // RULE12
    (timer_b_edge_level_select[3:2] != 2'h0)
      |-> (pf_oe[5] == timer_b_channel_pins_oe[1]) && (pf_out[5] == timer_b_channel_pins_out[1])
  ) else $error("timer B channel 1 not routed to port F pin 5");

  timer_in_a: assert property ( // RULE11 RULE12
    (timer_a_channel_pins_in == pf_in[3:0]) && (timer_b_channel_pins_in == pf_in[5:4])
  ) else $error("timer channel inputs not taken from port F");

  pin_oe_e_a: assert property ( // RULE1 RULE19
    (pe_oe & ~pe_alt_sel) == (e_dir & ~pe_alt_sel)
  ) else $error("free port E buffer does not follow direction");

  dir_e_readback_a: assert property ( // RULE18
    (we_e_dir ##1 (rd && addr == gio_pkg::OFS_E_DIR && !we_e_dir))
      |=> rdata == $past(wdata, 2)
  ) else $error("port E direction readback mismatch");

  upper_g_zero_a: assert property ( // RULE20
    (rd && addr == gio_pkg::OFS_G_DATA) |=> rdata[7:3] == 5'h00
  ) else $error("unused port G data bits read as one");

  latch_write_a: assert property ( // RULE8
    we_f_data |=> f_latch == $past(wdata[6:0])
  ) else $error("port F latch missed a write");

  rdata_reset_a: assert property (
    @(posedge clk) disable iff (1'b0) rst |=> rdata == gio_pkg::RDATA_RST
  ) else $error("read data not cleared by reset");

endmodule : gio_ports_e_to_h

// File: gio_pin_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Pin level model: an enabled buffer wins, else the outside level shows
module gio_pin_model #(
  parameter int W = 8
) (
  // Design side
  input  wire logic [W-1:0] drv,
  input  wire logic [W-1:0] oe,
  // Outside world
  input  wire logic [W-1:0] ext,
  output logic      [W-1:0] pin
);
  // Undriven pins follow the outside driver, never a stale value
  assign pin = (oe & drv) | (~oe & ext);
endmodule : gio_pin_model

// File: tb.sv
`timescale 1ns/1ps
// ==========================================================================
// Testbench for ports E to H
module tb;
  logic        clk, rst, wr, rd;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, v;
  logic [7:0]  pe_in, pe_out, pe_oe, pe_ext, e_sel, e_out, e_oe;
  logic [6:0]  pf_in, pf_out, pf_oe, pf_ext;
  logic [7:0]  ta_els;
  logic [3:0]  ta_out, ta_oe, ta_in, tb_els;
  logic [1:0]  tb_out, tb_oe, tb_in;
  logic [2:0]  pg_in, pg_out, pg_oe, pg_ext;
  logic [1:0]  ph_in, ph_out, ph_oe, ph_ext;
  logic [4:0]  kb_en, kb_in;
  int          errors, n_tests;

  // ========================================================================
  // Design and pins
  gio_ports_e_to_h u_gio_ports_e_to_h (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pe_in(pe_in), .pe_out(pe_out), .pe_oe(pe_oe),
    .pe_alt_sel(e_sel), .pe_alt_out(e_out), .pe_alt_oe(e_oe), .pf_in(pf_in),
    .pf_out(pf_out), .pf_oe(pf_oe), .timer_a_edge_level_select(ta_els),
    .timer_a_channel_pins_out(ta_out), .timer_a_channel_pins_oe(ta_oe),
    .timer_a_channel_pins_in(ta_in), .timer_b_edge_level_select(tb_els),
    .timer_b_channel_pins_out(tb_out), .timer_b_channel_pins_oe(tb_oe),
    .timer_b_channel_pins_in(tb_in), .pg_in(pg_in), .pg_out(pg_out), .pg_oe(pg_oe),
    .ph_in(ph_in), .ph_out(ph_out), .ph_oe(ph_oe), .keyboard_irq_enable(kb_en),
    .keyboard_input(kb_in));
  gio_pin_model #(.W(8)) u_pe (.drv(pe_out), .oe(pe_oe), .ext(pe_ext), .pin(pe_in));
  gio_pin_model #(.W(7)) u_pf (.drv(pf_out), .oe(pf_oe), .ext(pf_ext), .pin(pf_in));
  gio_pin_model #(.W(3)) u_pg (.drv(pg_out), .oe(pg_oe), .ext(pg_ext), .pin(pg_in));
  gio_pin_model #(.W(2)) u_ph (.drv(ph_out), .oe(ph_oe), .ext(ph_ext), .pin(ph_in));

  // Clock of 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ========================================================================
  // Helpers
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg

  // Write then read with no gap between the strobes
  task automatic wr_rd(input logic [15:0] wa, input logic [7:0] d, input logic [15:0] ra,
                       output logic [7:0] q);
    @(posedge clk);
    addr  <= wa;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    addr <= ra;
    wr   <= 1'b0;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask : wr_rd

  function automatic logic [7:0] msk(input int i);
    case (i)
      0: return 8'hFF;
      1: return 8'h7F;
      2: return 8'h07;
      default: return 8'h03;
    endcase
  endfunction : msk

  function automatic logic [7:0] oe_of(input int i);
    case (i)
      0: return pe_oe;
      1: return {1'b0, pf_oe};
      2: return {5'h00, pg_oe};
      default: return {6'h00, ph_oe};
    endcase
  endfunction : oe_of

  task automatic set_ext(input logic [7:0] x);
    @(posedge clk);
    pe_ext <= x;
    pf_ext <= x[6:0];
    pg_ext <= x[2:0];
    ph_ext <= x[1:0];
  endtask : set_ext

  // ========================================================================
  // Scenarios
  task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
      rd_reg(gio_pkg::OFS_E_DIR + 16'(i), v);
      chk(v, 8'h00);
      chk(oe_of(i), 8'h00);
    end
  endtask : t_reset

  task automatic t_dir;
    for (int i = 0; i < 4; i++) begin
      wr_rd(gio_pkg::OFS_E_DIR + 16'(i), 8'hFF, gio_pkg::OFS_E_DIR + 16'(i), v);
      chk(v, msk(i));
    end
    rd_reg(16'h0010, v);
    chk(v, 8'h00);
  endtask : t_dir

  task automatic t_mux;
    set_ext(8'h33);
    for (int i = 0; i < 4; i++) begin
      wr_reg(gio_pkg::OFS_E_DATA + 16'(i), 8'h5A);
      wr_reg(gio_pkg::OFS_E_DIR + 16'(i), 8'h0F);
      rd_reg(gio_pkg::OFS_E_DATA + 16'(i), v);
      chk(v, (8'h0A | 8'h30) & msk(i));
      chk(oe_of(i), 8'h0F & msk(i));
      wr_reg(gio_pkg::OFS_E_DATA + 16'(i), 8'hA5);
      rd_reg(gio_pkg::OFS_E_DATA + 16'(i), v);
      chk(v, (8'h05 | 8'h30) & msk(i));
    end
    chk({3'h0, ph_out, pg_out}, 8'h0D);
  endtask : t_mux

  task automatic t_keep;
    for (int i = 0; i < 4; i++) wr_reg(gio_pkg::OFS_E_DATA + 16'(i), 8'hC3);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd_reg(gio_pkg::OFS_E_DIR + 16'(i), v);
      chk(v, 8'h00);
      wr_reg(gio_pkg::OFS_E_DIR + 16'(i), 8'hFF);
      rd_reg(gio_pkg::OFS_E_DATA + 16'(i), v);
      chk(v, 8'hC3 & msk(i));
    end
  endtask : t_keep

  // Timer A channel 2 takes pin 0, timer B channels 0 and 1 take pins 4 and 5
  task automatic t_timer;
    wr_reg(gio_pkg::OFS_F_DATA, 8'h00);
    wr_reg(gio_pkg::OFS_F_DIR, 8'h00);
    set_ext(8'h00);
    @(posedge clk);
    ta_els <= 8'h01;
    tb_els <= 4'hA;
    @(negedge clk);
    chk(pf_oe, 7'h31);
    chk(pf_out & 7'h31, 7'h11);
    chk(ta_in, 4'h1);
    chk(tb_in, 2'h1);
    rd_reg(gio_pkg::OFS_F_DATA, v);
    chk(v, 8'h11);
    wr_reg(gio_pkg::OFS_F_DIR, 8'h7F);
    rd_reg(gio_pkg::OFS_F_DATA, v);
    chk(v, 8'h00);
    chk(pf_oe, 7'h7F);
    @(posedge clk);
    ta_els <= 8'h00;
    tb_els <= 4'h0;
  endtask : t_timer

  task automatic t_pe_alt;
    wr_reg(gio_pkg::OFS_E_DIR, 8'h00);
    @(posedge clk);
    e_sel <= 8'hF1;
    e_out <= 8'hA1;
    e_oe  <= 8'hF1;
    @(negedge clk);
    chk(pe_oe, 8'hF1);
    chk(pe_out & 8'hF1, 8'hA1);
    rd_reg(gio_pkg::OFS_E_DATA, v);
    chk(v, 8'hA1);
    wr_reg(gio_pkg::OFS_E_DIR, 8'h0F);
    rd_reg(gio_pkg::OFS_E_DATA, v);
    chk(v, 8'hA3);
    chk(pe_oe, 8'hFF);
  endtask : t_pe_alt

  task automatic t_kbd;
    wr_reg(gio_pkg::OFS_G_DIR, 8'h00);
    wr_reg(gio_pkg::OFS_H_DIR, 8'h00);
    set_ext(8'hFF);
    wr_rd(gio_pkg::OFS_G_DATA, 8'h02, gio_pkg::OFS_G_DATA, v);
    chk(v, 8'h07);
    @(posedge clk);
    kb_en <= 5'h15;
    @(negedge clk);
    chk(kb_in, 5'h15);
    @(posedge clk);
    kb_en <= 5'h0A;
    @(negedge clk);
    chk(kb_in, 5'h0A);
  endtask : t_kbd

  // ========================================================================
  // Verdict
  task automatic end_sim;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // Watchdog well beyond the roughly 150 cycles of the run
  initial begin
    #200000;
    errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    errors = 0;
    n_tests = 0;
    rst <= 1'b1;
    {wr, rd, addr, wdata} <= '0;
    {pe_ext, e_sel, e_out, e_oe, pf_ext, pg_ext, ph_ext} <= '0;
    {ta_els, tb_els, kb_en} <= '0;
    ta_out <= 4'hF;
    ta_oe  <= 4'hF;
    tb_out <= 2'h1;
    tb_oe  <= 2'h3;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_dir();
    t_mux();
    t_keep();
    t_timer();
    t_pe_alt();
    t_kbd();
    end_sim();
  end
endmodule : tb
